// File: flash_consts.vh
// Opcodes, status word layout, reset values and timing for the flash front end
`ifndef FLASH_CONSTS_VH
`define FLASH_CONSTS_VH

`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_STATUS_READ1 8'h05
`define OP_STATUS_READ2 8'h35
`define OP_STATUS_READ3 8'h15
`define OP_STATUS_WRITE1 8'h01
`define OP_STATUS_WRITE2 8'h31
`define OP_STATUS_WRITE3 8'h11
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE32 8'h52
`define OP_BLOCK_ERASE64 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99
`define OP_DEEP_PD 8'hb9
`define OP_RELEASE_PD 8'hab
`define OP_HIGH_PERF 8'ha3

// Status word bit positions
`define SW_BUSY 0
`define SW_WRITE_ENABLE 1
`define SW_PSIZE_LO 2
`define SW_PMODE_LOWER 7
`define SW_PMODE_UPPER 8
`define SW_QUAD 9
`define SW_PROG_SUSP 10
`define SW_LOCK_LO 11
`define SW_COMPLEMENT 14
`define SW_ERASE_SUSP 15
`define SW_HIGH_PERF 20
`define SW_DRIVE_LO 21

// Reset values
`define PSIZE_RESET 5'h00
`define PMODE_RESET 2'h0
`define LOCK_RESET 3'h0
`define COMPLEMENT_RESET 1'h0
`define DRIVE_RESET 2'h1
`define QUAD_RESET 1'h1

// Operation kinds reported on op_kind
`define KIND_PROGRAM 2'h1
`define KIND_ERASE 2'h2
`define KIND_STATUS 2'h3
`define KIND_CHIP 2'h0

// Array timing, in microseconds, and clock rate in MHz
`define CLK_MHZ 40
`define PROG_TIME_US 600
`define ERASE_TIME_US 50000
`define CHIP_TIME_US 2000000
`define STATUS_TIME_US 5000
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`define CHIP_CYCLES (`CHIP_TIME_US * `CLK_MHZ)
`define STATUS_CYCLES (`STATUS_TIME_US * `CLK_MHZ)

`endif

// File: spi_frame.v
// Serial link front end: pin synchronisers, bit framing and status shift-out
`timescale 1ns/1ps
module spi_frame (
	input wire clk,
	input wire nrst,
	input wire sclk,
	input wire cs_n,
	input wire si,
	input wire [7:0] tx_byte,
	input wire tx_load,
	output reg frame_start,
	output reg frame_end,
	output reg frame_aligned,
	output reg byte_done,
	output reg [7:0] rx_byte,
	output reg so,
	output reg so_oe
);
	reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
	reg cs_s1_r, cs_s2_r, cs_s3_r;
	reg si_s1_r, si_s2_r;
	reg [6:0] shin_r;
	reg [2:0] bit_cnt_r;
	reg any_bit_r;
	reg [7:0] shout_r;
	wire rise = sclk_s2_r & ~sclk_s3_r;
	wire fall = ~sclk_s2_r & sclk_s3_r;
	wire cs_act = ~cs_s2_r;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_s3_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			si_s1_r <= 1'b0;
			si_s2_r <= 1'b0;
		end else begin
			sclk_s1_r <= sclk;
			sclk_s2_r <= sclk_s1_r;
			sclk_s3_r <= sclk_s2_r;
			cs_s1_r <= cs_n;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			si_s1_r <= si;
			si_s2_r <= si_s1_r;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shin_r <= 7'h00;
			bit_cnt_r <= 3'h0;
			any_bit_r <= 1'b0;
			byte_done <= 1'b0;
			rx_byte <= 8'h00;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
			frame_aligned <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			frame_start <= cs_act & cs_s3_r;
			frame_end <= cs_s2_r & ~cs_s3_r;
			// Clock count since select fell must be a whole number of bytes, see [R19]
			frame_aligned <= cs_s2_r & ~cs_s3_r & any_bit_r & (bit_cnt_r == 3'h0);
			if (cs_act & cs_s3_r) begin
				bit_cnt_r <= 3'h0;
				any_bit_r <= 1'b0;
			end else if (rise & cs_act) begin
				// MSB first, latched on the rising edge, see [R15]
				shin_r <= {shin_r[5:0], si_s2_r};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				any_bit_r <= 1'b1;
				if (bit_cnt_r == 3'h7) begin
					byte_done <= 1'b1;
					rx_byte <= {shin_r, si_s2_r};
				end
			end
		end
	end

	// Output bits leave on falling edges so the host samples them on the next rise
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shout_r <= 8'h00;
			so <= 1'b0;
			so_oe <= 1'b0;
		end else if (!cs_act) begin
			// Raising select ends a read at any bit, see [R18]
			so_oe <= 1'b0;
		end else if (tx_load) begin
			shout_r <= tx_byte;
			so_oe <= 1'b1;
		end else if (fall & so_oe) begin
			so <= shout_r[7];
			shout_r <= {shout_r[6:0], 1'b0};
		end
	end
endmodule

// File: flash_status_ctrl.v
// Status word and command execution for the serial flash front end
// Notes on behaviour
// [R1] Busy set during program, erase, status write
// [R2] Write enable gates status write, program, erase
// [R3] Protect-size bits block program and erase there
// [R4] Chip erase only when protect bits allow
// [R5] Upper mode bit clear: writes need latch only
// [R6] Mode (1,0) locks writes until power cycle
// [R7] Mode (1,1) locks status writes forever; code clears it on reset, same as (1,0)
// [R8] Quad enable always reads one, never changes
// [R9] Security locks set once, never clear, read-only; code clears them on reset
// [R10] Complement bit inverts the protected region
// [R11] Suspend sets erase or program suspended flag
// [R12] Resume, software reset, power cycle clear suspends
// [R13] High-performance flag shows high-performance mode
// [R14] Two-bit drive-strength field, default three quarters
// [R15] Bits MSB first, latched on rising clock
// [R16] Host opens each frame with one opcode byte
// [R17] Host raises select after the last bit
// [R18] Reads shift out until select rises
// [R19] Writes execute only on whole-byte frame ends
// [R20] Partial page program does nothing, latch kept
// [R21] Read-only status bits ignore writes
// [R22] Completed write operation clears the latch
`timescale 1ns/1ps
`include "flash_consts.vh"
module flash_status_ctrl #(
	parameter [31:0] PROG_CYCLES = `PROG_CYCLES,
	parameter [31:0] ERASE_CYCLES = `ERASE_CYCLES,
	parameter [31:0] CHIP_CYCLES = `CHIP_CYCLES,
	parameter [31:0] STATUS_CYCLES = `STATUS_CYCLES
) (
	input wire clk,
	input wire nrst,
	input wire sclk,
	input wire cs_n,
	input wire si,
	output wire so,
	output wire so_oe,
	output reg busy,
	output reg [1:0] drive_strength,
	output reg quad_io_enable,
	output reg security_ro,
	output reg op_start,
	output reg [1:0] op_kind,
	output reg [23:0] op_addr
);
	wire frame_start, frame_end, frame_aligned, byte_done;
	wire [7:0] rx_byte;
	reg [7:0] tx_byte_r;
	reg tx_load_r;
	reg [7:0] opcode_r;
	reg [2:0] nbytes_r;
	reg [23:0] addr_r;
	reg [7:0] data_r;
	reg wel_r;
	reg [4:0] psize_r;
	reg [1:0] pmode_r;
	reg [2:0] lock_r;
	reg cmp_r;
	reg sus_erase_r;
	reg sus_prog_r;
	reg hpf_r;
	reg dpd_r;
	reg rst_en_r;
	reg [1:0] kind_r;
	reg [31:0] cnt_r;
	wire [23:0] word;

	spi_frame u_frame (
		.clk(clk),
		.nrst(nrst),
		.sclk(sclk),
		.cs_n(cs_n),
		.si(si),
		.tx_byte(tx_byte_r),
		.tx_load(tx_load_r),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.frame_aligned(frame_aligned),
		.byte_done(byte_done),
		.rx_byte(rx_byte),
		.so(so),
		.so_oe(so_oe)
	);

	// Reserved positions read as zero; quad enable is a constant one, see [R8]
	assign word = {1'b0, drive_strength, hpf_r, 4'h0, sus_erase_r, cmp_r, lock_r,
		sus_prog_r, 1'b1, pmode_r, psize_r, wel_r, busy};

	function is_status_read;
		input [7:0] op;
		begin
			is_status_read = (op == `OP_STATUS_READ1) || (op == `OP_STATUS_READ2) ||
				(op == `OP_STATUS_READ3);
		end
	endfunction

	function [7:0] status_byte;
		input [7:0] op;
		input [23:0] w;
		begin
			if (op == `OP_STATUS_READ2)
				status_byte = w[15:8];
			else if (op == `OP_STATUS_READ3)
				status_byte = w[23:16];
			else
				status_byte = w[7:0];
		end
	endfunction

	// Region selected by protect-size and complement bits on an 8 MB array
	function is_protected;
		input [23:0] a;
		input [4:0] ps;
		input cmp;
		reg [4:0] e;
		reg [22:0] mask;
		reg hit;
		begin
			e = 5'd0;
			mask = 23'h0;
			hit = 1'b0;
			if (ps[2:0] == 3'h0) begin
				hit = 1'b0;
			end else if (ps[2:0] == 3'h7) begin
				hit = 1'b1;
			end else begin
				if (!ps[4])
					e = 5'd16 + {2'b00, ps[2:0]};
				else if (ps[2:0] > 3'h3)
					e = 5'd15;
				else
					e = 5'd11 + {2'b00, ps[2:0]};
				mask = ~((23'h1 << e) - 23'h1);
				if (ps[3])
					hit = ((a[22:0] & mask) == 23'h0);
				else
					hit = ((a[22:0] & mask) == mask);
			end
			is_protected = hit ^ cmp; // see [R3] [R10]
		end
	endfunction

	function is_erase;
		input [7:0] op;
		begin
			is_erase = (op == `OP_SECTOR_ERASE) || (op == `OP_BLOCK_ERASE32) ||
				(op == `OP_BLOCK_ERASE64);
		end
	endfunction

	// Opcode, address and first data byte capture; status reads refill per byte
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			opcode_r <= 8'h00;
			nbytes_r <= 3'h0;
			addr_r <= 24'h000000;
			data_r <= 8'h00;
			tx_byte_r <= 8'h00;
			tx_load_r <= 1'b0;
		end else begin
			tx_load_r <= 1'b0;
			if (frame_start) begin
				nbytes_r <= 3'h0;
			end else if (byte_done) begin
				if (nbytes_r != 3'h5)
					nbytes_r <= nbytes_r + 3'h1;
				if (nbytes_r == 3'h0)
					opcode_r <= rx_byte;
				if (nbytes_r == 3'h1)
					data_r <= rx_byte;
				if (nbytes_r != 3'h0 && nbytes_r < 3'h4)
					addr_r <= {addr_r[15:0], rx_byte};
				// Read status repeats the same byte while the clock runs, see [R18]
				if (nbytes_r == 3'h0 && is_status_read(rx_byte) && !dpd_r) begin
					tx_byte_r <= status_byte(rx_byte, word);
					tx_load_r <= 1'b1;
				end else if (nbytes_r != 3'h0 && is_status_read(opcode_r) && !dpd_r) begin
					tx_byte_r <= status_byte(opcode_r, word);
					tx_load_r <= 1'b1;
				end
			end
		end
	end

	wire idle_ok = frame_end && frame_aligned && !busy && !dpd_r;
	wire one_byte = (nbytes_r == 3'h1);
	wire has_addr = (nbytes_r >= 3'h4);
	// Upper mode bit set, in either lock mode, rejects status writes, see [R5] [R6] [R7]
	wire sw_ok = wel_r && !pmode_r[1] && (nbytes_r >= 3'h2);
	wire is_sw = (opcode_r == `OP_STATUS_WRITE1) || (opcode_r == `OP_STATUS_WRITE2) ||
		(opcode_r == `OP_STATUS_WRITE3);
	wire chip_ok = ((psize_r[2:0] == 3'h0) && !cmp_r) || ((psize_r[2:0] == 3'h7) && cmp_r);
	wire do_prog = idle_ok && (opcode_r == `OP_PAGE_PROGRAM) && wel_r && has_addr &&
		!is_protected(addr_r, psize_r, cmp_r);
	wire do_erase = idle_ok && is_erase(opcode_r) && wel_r && has_addr &&
		!is_protected(addr_r, psize_r, cmp_r);
	wire do_chip = idle_ok && one_byte && wel_r && chip_ok &&
		((opcode_r == `OP_CHIP_ERASE_A) || (opcode_r == `OP_CHIP_ERASE_B));
	wire do_sw = idle_ok && is_sw && sw_ok;
	wire do_reset = frame_end && frame_aligned && one_byte && rst_en_r &&
		(opcode_r == `OP_RESET);
	wire done = busy && (cnt_r == 32'h1);

	// Operation timer, busy flag and write-enable latch
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			cnt_r <= 32'h0;
			kind_r <= `KIND_CHIP;
			wel_r <= 1'b0;
			sus_erase_r <= 1'b0;
			sus_prog_r <= 1'b0;
			op_start <= 1'b0;
			op_kind <= `KIND_CHIP;
			op_addr <= 24'h000000;
		end else begin
			op_start <= 1'b0;
			if (busy)
				cnt_r <= cnt_r - 32'h1;
			if (done) begin
				busy <= 1'b0; // see [R1]
				wel_r <= 1'b0; // see [R22]
			end
			if (do_reset) begin
				// Abort and clear volatile state, see [R12]
				busy <= 1'b0;
				wel_r <= 1'b0;
				sus_erase_r <= 1'b0;
				sus_prog_r <= 1'b0;
			end else if (do_prog || do_erase || do_chip || do_sw) begin
				// Every write-type command needs the latch set, see [R2] [R4] [R19]
				busy <= 1'b1; // see [R1]
				op_start <= 1'b1;
				op_addr <= addr_r;
				if (do_prog) begin
					cnt_r <= PROG_CYCLES;
					kind_r <= `KIND_PROGRAM;
					op_kind <= `KIND_PROGRAM;
				end else if (do_erase) begin
					cnt_r <= ERASE_CYCLES;
					kind_r <= `KIND_ERASE;
					op_kind <= `KIND_ERASE;
				end else if (do_chip) begin
					cnt_r <= CHIP_CYCLES;
					kind_r <= `KIND_CHIP;
					op_kind <= `KIND_CHIP;
				end else begin
					cnt_r <= STATUS_CYCLES;
					kind_r <= `KIND_STATUS;
					op_kind <= `KIND_STATUS;
				end
			end else if (frame_end && frame_aligned && one_byte && !dpd_r) begin
				// A misaligned frame never reaches here, so the latch survives, see [R20]
				// A suspend landing on the last timer cycle would strand a zero count
				if (opcode_r == `OP_SUSPEND && busy && !done && kind_r != `KIND_STATUS) begin
					busy <= 1'b0;
					if (kind_r == `KIND_PROGRAM)
						sus_prog_r <= 1'b1; // see [R11]
					else
						sus_erase_r <= 1'b1; // see [R11]
				end else if (opcode_r == `OP_RESUME && (sus_erase_r || sus_prog_r)) begin
					busy <= 1'b1;
					sus_erase_r <= 1'b0; // see [R12]
					sus_prog_r <= 1'b0;
				end else if (!busy && opcode_r == `OP_WR_ENABLE) begin
					wel_r <= 1'b1; // see [R19]
				end else if (!busy && opcode_r == `OP_WR_DISABLE) begin
					wel_r <= 1'b0;
				end
			end
		end
	end

	// Status word fields written by the status write commands
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			psize_r <= `PSIZE_RESET;
			pmode_r <= `PMODE_RESET;
			lock_r <= `LOCK_RESET;
			cmp_r <= `COMPLEMENT_RESET;
			drive_strength <= `DRIVE_RESET;
		end else if (do_sw) begin
			// Busy, latch, quad, suspend and performance bits are not written, see [R21]
			if (opcode_r == `OP_STATUS_WRITE1) begin
				pmode_r[0] <= data_r[`SW_PMODE_LOWER];
				psize_r <= data_r[6:2]; // see [R3]
			end else if (opcode_r == `OP_STATUS_WRITE2) begin
				pmode_r[1] <= data_r[`SW_PMODE_UPPER - 8];
				cmp_r <= data_r[`SW_COMPLEMENT - 8]; // see [R10]
				lock_r <= lock_r | data_r[5:3]; // see [R9]
			end else begin
				drive_strength <= data_r[6:5]; // see [R14]
			end
		end
	end

	// Mode flags, reset arming and registered quad enable and security lock outputs
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hpf_r <= 1'b0;
			dpd_r <= 1'b0;
			rst_en_r <= 1'b0;
			quad_io_enable <= `QUAD_RESET;
			security_ro <= 1'b0;
		end else begin
			quad_io_enable <= `QUAD_RESET; // see [R8]
			security_ro <= |lock_r; // see [R9]
			if (do_reset)
				hpf_r <= 1'b0;
			else if (idle_ok && one_byte && opcode_r == `OP_HIGH_PERF)
				hpf_r <= 1'b1; // see [R13]
			else if (frame_end && !busy && one_byte && opcode_r == `OP_RELEASE_PD)
				hpf_r <= 1'b0;
			if (idle_ok && one_byte && opcode_r == `OP_DEEP_PD)
				dpd_r <= 1'b1; // see [R19]
			else if (frame_end && opcode_r == `OP_RELEASE_PD && nbytes_r != 3'h0)
				dpd_r <= 1'b0;
			// Reset arms only when the enable frame is directly followed by reset
			if (frame_end && nbytes_r != 3'h0)
				rst_en_r <= frame_aligned && one_byte && (opcode_r == `OP_RESET_ENABLE);
		end
	end
endmodule

// File: spi_host_model.sv
// Host side serial controller model for the flash link
`timescale 1ns/1ps
module spi_host_model (
	input wire clk,
	input wire so,
	input wire so_oe,
	output reg sclk,
	output reg cs_n,
	output reg si
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// Shifts the low n bits of d, keeps the last eight bits seen on so
	task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
		rd = 8'h00;
		tick(1);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si = d[i];
			tick(4);
			sclk = 1'b1;
			tick(4);
			rd = {rd[6:0], (so_oe === 1'b1) ? so : 1'bx};
			sclk = 1'b0;
		end
		tick(4);
		cs_n = 1'b1;
		// Released line: never leave the last bit looking valid
		si = ~si;
		tick(8);
	endtask
endmodule

// File: flash_status_props.sv
// Port checks for the flash status and command front end
`timescale 1ns/1ps
module flash_status_props #(
	parameter [31:0] PROG_CYCLES = 20,
	parameter [31:0] ERASE_CYCLES = 40,
	parameter [31:0] CHIP_CYCLES = 60,
	parameter [31:0] STATUS_CYCLES = 30
) (
	input wire clk,
	input wire nrst,
	input wire sclk,
	input wire cs_n,
	input wire si,
	input wire so,
	input wire so_oe,
	input wire busy,
	input wire [1:0] drive_strength,
	input wire quad_io_enable,
	input wire security_ro,
	input wire op_start,
	input wire [1:0] op_kind,
	input wire [23:0] op_addr
);
	localparam int STAT_HI = STATUS_CYCLES + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	start_busy_a: assert property (op_start |-> busy)
		else $error("busy low at accept");
	status_span_a: assert property (
		op_start && op_kind == 2'h3 |-> busy [*8] ##[1:STAT_HI] !busy)
		else $error("status write busy span wrong");
	no_accept_busy_a: assert property (op_start |-> !$past(busy))
		else $error("operation accepted while busy");
	start_pulse_a: assert property (op_start |=> !op_start)
		else $error("accept pulse too long");
	start_at_end_a: assert property (op_start |-> cs_n && $past(cs_n, 3))
		else $error("accept before frame end");
	quad_fixed_a: assert property (quad_io_enable)
		else $error("quad enable dropped");
	drive_reset_a: assert property ($rose(nrst) |-> drive_strength == 2'h1)
		else $error("drive strength reset wrong");
	drive_write_a: assert property (
		$changed(drive_strength) |-> op_kind == 2'h3 && (op_start || $past(op_start)))
		else $error("drive strength changed without write");
	lock_sticky_a: assert property (!$fell(security_ro))
		else $error("security lock cleared");
	oe_select_a: assert property ($rose(so_oe) |-> !cs_n)
		else $error("output enabled while deselected");
	oe_release_a: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
		else $error("output kept after deselect");
endmodule
bind flash_status_ctrl flash_status_props #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES), .CHIP_CYCLES(CHIP_CYCLES), .STATUS_CYCLES(STATUS_CYCLES))
	props_u (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
	.busy(busy), .drive_strength(drive_strength), .quad_io_enable(quad_io_enable),
	.security_ro(security_ro), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr));

// File: tb.sv
// Self-checking bench for the flash status and command front end
`timescale 1ns/1ps
`include "flash_consts.vh"
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	wire sclk, cs_n, si, so, so_oe, busy, quad_io_enable, security_ro, op_start;
	wire [1:0] drive_strength, op_kind;
	wire [23:0] op_addr;
	int bad_count = 0;
	int tests_run = 0;
	logic [23:0] starts = 24'h0;
	logic [1:0] kind_seen;
	logic [23:0] addr_seen;
	logic [7:0] rd;
	initial forever #12.5 clk = ~clk;
	// Long enough operations that suspend lands mid-run
	flash_status_ctrl #(.PROG_CYCLES(400), .ERASE_CYCLES(400), .CHIP_CYCLES(60),
		.STATUS_CYCLES(30)) dut_u (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .busy(busy), .drive_strength(drive_strength),
		.quad_io_enable(quad_io_enable), .security_ro(security_ro), .op_start(op_start),
		.op_kind(op_kind), .op_addr(op_addr));
	spi_host_model host_u (.clk(clk), .so(so), .so_oe(so_oe), .sclk(sclk), .cs_n(cs_n), .si(si));
	always @(posedge clk) begin
		if (op_start === 1'b1) begin
			starts <= starts + 24'h1;
			kind_seen <= op_kind;
			addr_seen <= op_addr;
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [31:0] d, input int n);
		host_u.frame(d, n, rd);
	endtask
	task automatic rdsr(input logic [7:0] op, input logic [7:0] exp);
		cmd({op, 8'h00}, 16);
		check(rd, exp);
	endtask
	// A wait that runs out is counted as a mismatch
	task automatic idle;
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
		#2;
		check(busy, 1'b0);
	endtask
	task automatic wr(input logic [31:0] d, input int n);
		cmd(32'h06, 8);
		cmd(d, n);
		idle();
	endtask
	task automatic stop_test;
		if (bad_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		#2 nrst = 1'b1;
		repeat (4) @(posedge clk);
		rdsr(8'h05, 8'h00);
		rdsr(8'h35, 8'h02);
		rdsr(8'h15, 8'h20);
		check(quad_io_enable, 1'b1);
		cmd({8'h01, 8'h1c}, 16);
		rdsr(8'h05, 8'h00);
		cmd(32'h06, 7);
		rdsr(8'h05, 8'h00);
		cmd(32'h06, 8);
		rdsr(8'h05, 8'h02);
		cmd(32'h04, 8);
		rdsr(8'h05, 8'h00);
		check(starts, 24'h0);
		wr({8'h01, 8'h1f}, 16);
		check(kind_seen, `KIND_STATUS);
		rdsr(8'h05, 8'h1c);
		cmd(32'h06, 8);
		cmd(32'h02123456, 32);
		cmd(32'hc7, 8);
		rdsr(8'h05, 8'h1e);
		check(starts, 24'h1);
		cmd({8'h31, 8'h40}, 16);
		idle();
		rdsr(8'h35, 8'h42);
		wr(32'hc7, 8);
		check(kind_seen, `KIND_CHIP);
		cmd(32'h06, 8);
		cmd(28'h0200100, 28);
		rdsr(8'h05, 8'h1e);
		check(starts, 24'h3);
		cmd(32'h027ff000, 32);
		check(addr_seen, 24'h7ff000);
		check(kind_seen, `KIND_PROGRAM);
		cmd(32'h75, 8);
		rdsr(8'h35, 8'h46);
		check(busy, 1'b0);
		cmd(32'h7a, 8);
		rdsr(8'h35, 8'h42);
		check(busy, 1'b1);
		idle();
		cmd(32'h06, 8);
		cmd(32'h20000000, 32);
		cmd(32'h75, 8);
		rdsr(8'h35, 8'hc2);
		cmd(32'h66, 8);
		cmd(32'h99, 8);
		rdsr(8'h35, 8'h42);
		check(busy, 1'b0);
		// Deep power-down refuses write enable until released
		cmd(32'hb9, 8);
		cmd(32'h06, 8);
		cmd(32'hab, 8);
		rdsr(8'h05, 8'h1c);
		for (int d = 0; d < 4; d++) begin
			wr({8'h11, 1'b0, d[1:0], 5'h00}, 16);
			check(drive_strength, d[1:0]);
			rdsr(8'h15, {1'b0, d[1:0], 5'h00});
		end
		wr({8'h11, 8'hff}, 16);
		rdsr(8'h15, 8'h60);
		cmd(32'ha3, 8);
		rdsr(8'h15, 8'h70);
		cmd(32'hab, 8);
		rdsr(8'h15, 8'h60);
		wr({8'h31, 8'h48}, 16);
		rdsr(8'h35, 8'h4a);
		check(security_ro, 1'b1);
		wr({8'h31, 8'h40}, 16);
		rdsr(8'h35, 8'h4a);
		wr({8'h31, 8'h49}, 16);
		wr({8'h01, 8'h00}, 16);
		rdsr(8'h05, 8'h1e);
		// Power cycle; no retention model, so every bit returns to default
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#2 nrst = 1'b1;
		repeat (4) @(posedge clk);
		rdsr(8'h35, 8'h02);
		check(drive_strength, 2'h1);
		wr({8'h01, 8'h80}, 16);
		rdsr(8'h05, 8'h80);
		wr({8'h31, 8'h01}, 16);
		wr({8'h11, 8'h60}, 16);
		check(drive_strength, 2'h1);
		rdsr(8'h35, 8'h03);
		stop_test();
	end
endmodule
